// ### core/aic_regs.svh
`ifndef AIC_REGS_SVH
`define AIC_REGS_SVH

// Register byte offsets on the control bus
`define AIC_OFS_MODE      8'h00
`define AIC_OFS_STEPOUT   8'h04
`define AIC_OFS_OFFERR    8'h08
`define AIC_OFS_MOTOR     8'h0c
`define AIC_OFS_IN_SEL    8'h10
`define AIC_OFS_IN_VAL    8'h14
`define AIC_OFS_LIM       8'h18
`define AIC_OFS_AXIS_SEL  8'h1c
`define AIC_OFS_POS       8'h20
`define AIC_OFS_LATCH_POS 8'h24
`define AIC_OFS_LATCH_CFG 8'h28
`define AIC_OFS_IRQ_STAT  8'h2c
`define AIC_OFS_IRQ_MASK  8'h30
`define AIC_OFS_GEN_IN    8'h34
`define AIC_OFS_LAST_ERR  8'h38

// Bit positions of the field pin groups inside the raw input vector
`define AIC_F_GEN   0
`define AIC_F_ENC1  16
`define AIC_F_ENC2  24
`define AIC_F_AUX1  32
`define AIC_F_AUX2  40
`define AIC_F_FWD   48
`define AIC_F_REV   56

// Interrupt status layout
`define AIC_IRQ_LIM   0
`define AIC_IRQ_LATCH 8
`define AIC_IRQ_BEGIN 16

// Input numbering, error code, reset values and clock rates
`define AIC_BANK_SIZE  8
`define AIC_AUX_BASE   7'd81
`define AIC_ERR_LIMIT  8'd22
`define AIC_RST_MASK   17'h00000
`define AIC_RST_INSEL  7'h01
`define AIC_CLK_HZ     25000000
`define AIC_QUAD_HZ    15000000

`endif

// ### core/aic_pkg.sv
package aic_pkg;

    // Write channel sequencing of the bus slave
    typedef enum logic [1:0] {
        AIC_WR_IDLE = 2'b01,
        AIC_WR_RESP = 2'b10
    } aic_wr_st_t;

    // AXI4-Lite master to slave signals
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } aic_axi_req_t;

    // AXI4-Lite slave to master signals
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } aic_axi_rsp_t;

    // Field pins, switches active low
    typedef struct packed {
        logic [7:0]  reverse_travel_switch_b;
        logic [7:0]  forward_travel_switch_b;
        logic [7:0]  aux_channel_second;
        logic [7:0]  aux_channel_first;
        logic [7:0]  encoder_channel_two;
        logic [7:0]  encoder_channel_one;
        logic [15:0] general_input;
    } aic_field_t;

    // Whole state of the block
    typedef struct packed {
        logic [63:0]      s1;
        logic [63:0]      s2;
        logic [63:0]      s3;
        logic [7:0][31:0] pos;
        logic [7:0][31:0] latch_pos;
        logic [7:0]       mode;
        logic [7:0]       stepout;
        logic [7:0]       offerr;
        logic [7:0]       axis_off;
        logic [7:0]       lat_arm;
        logic [3:0]       lat_src;
        logic [6:0]       in_sel;
        logic [2:0]       axis_sel;
        logic [16:0]      irq_stat;
        logic [16:0]      irq_mask;
        logic [7:0]       last_err;
        logic             begin_grant;
        logic             begin_reject;
        logic             branch;
        aic_wr_st_t       wr;
        logic             got_aw;
        logic             got_w;
        logic [7:0]       awaddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } aic_state_t;

endpackage

// ### core/aic_input_cond.sv
`timescale 1ns/1ps
`include "aic_regs.svh"

module aic_input_cond #(
    parameter int N_AXES = 8
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    input  wire aic_pkg::aic_axi_req_t axi_req,
    output aic_pkg::aic_axi_rsp_t     axi_rsp,
    input  wire aic_pkg::aic_field_t  field,
    input  wire logic                 begin_req,
    input  wire logic [2:0]           begin_axis,
    input  wire logic                 begin_fwd,
    input  wire logic                 handler_present,
    output logic                      begin_grant,
    output logic                      begin_reject,
    output logic                      thread0_branch,
    output logic [7:0]                fwd_inhibit,
    output logic [7:0]                rev_inhibit,
    output logic [7:0]                motor_enable,
    output logic [7:0]                fwd_limit_state,
    output logic [7:0]                rev_limit_state,
    output logic [15:0]               general_input,
    output logic [7:0][31:0]          enc_pos,
    output logic                      irq
);

    // A 25 MHz sampling clock limits honest edge rates; see the note on counting
    localparam int         N_GEN     = (N_AXES > 4) ? 16 : 8;
    localparam logic [8:0] AM9       = (9'h001 << N_AXES) - 9'h001;
    localparam logic [7:0] AXIS_MASK = AM9[7:0];
    localparam logic [15:0] GEN_MASK = (N_AXES > 4) ? 16'hffff : 16'h00ff;

    // Every per-axis field is eight lanes wide, so more axes cannot be served
    if (N_AXES < 1 || N_AXES > 8) begin : g_bad_axes
        $error("N_AXES must lie between 1 and 8");
    end

    aic_pkg::aic_state_t q;
    aic_pkg::aic_state_t n;

    logic [7:0]  a_new, a_old, b_new, b_old;
    logic [7:0]  fwd_act, rev_act, lim_edge;
    logic [15:0] gen_chg;
    logic        aw_take, w_take, wr_fire, ar_take;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [31:0] rd_data;
    logic        rd_hit;
    logic        in_val;
    logic [6:0]  aux_rel;

    // Byte-lane merge of a write onto a register's old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Views of the synchronised field; only the second and third stages are read
    assign a_new    = q.s2[`AIC_F_ENC1 +: 8];
    assign a_old    = q.s3[`AIC_F_ENC1 +: 8];
    assign b_new    = q.s2[`AIC_F_ENC2 +: 8];
    assign b_old    = q.s3[`AIC_F_ENC2 +: 8];
    assign fwd_act  = ~q.s2[`AIC_F_FWD +: 8] & AXIS_MASK;
    assign rev_act  = ~q.s2[`AIC_F_REV +: 8] & AXIS_MASK;
    assign lim_edge = ((q.s3[`AIC_F_FWD +: 8] & ~q.s2[`AIC_F_FWD +: 8])
                    | (q.s3[`AIC_F_REV +: 8] & ~q.s2[`AIC_F_REV +: 8])) & AXIS_MASK;
    assign gen_chg  = (q.s2[`AIC_F_GEN +: 16] ^ q.s3[`AIC_F_GEN +: 16]) & GEN_MASK;

    // Bus handshakes: address and data taken in either order, answer after both
    assign aw_take = axi_req.awvalid && q.wr == aic_pkg::AIC_WR_IDLE && !q.got_aw;
    assign w_take  = axi_req.wvalid && q.wr == aic_pkg::AIC_WR_IDLE && !q.got_w;
    assign wr_fire = (q.got_aw || aw_take) && (q.got_w || w_take);
    assign wr_addr = q.got_aw ? q.awaddr : axi_req.awaddr;
    assign wr_data = q.got_w ? q.wdata : axi_req.wdata;
    assign wr_strb = q.got_w ? q.wstrb : axi_req.wstrb;
    assign ar_take = axi_req.arvalid && !q.rvalid;

    // Indexed single-input read; aux inputs vanish on stepper axes
    assign aux_rel = q.in_sel - `AIC_AUX_BASE;
    always_comb begin
        in_val = 1'b0;
        if (q.in_sel >= 7'd1 && q.in_sel <= 7'(N_GEN)) begin
            in_val = q.s2[`AIC_F_GEN + 32'(q.in_sel) - 1];
        end else if (q.in_sel >= `AIC_AUX_BASE && aux_rel < 7'(2 * N_AXES)) begin
            if (!q.stepout[aux_rel[3:1]]) begin
                in_val = aux_rel[0] ? q.s2[`AIC_F_AUX2 + 32'(aux_rel[3:1])]
                                    : q.s2[`AIC_F_AUX1 + 32'(aux_rel[3:1])];
            end
        end
    end

    // Read decode; unmapped addresses answer with an error and zero data
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (axi_req.araddr)
            `AIC_OFS_MODE:      rd_data[7:0]  = q.mode;
            `AIC_OFS_STEPOUT:   rd_data[7:0]  = q.stepout;
            `AIC_OFS_OFFERR:    rd_data[7:0]  = q.offerr;
            `AIC_OFS_MOTOR:     rd_data[7:0]  = q.axis_off;
            `AIC_OFS_IN_SEL:    rd_data[6:0]  = q.in_sel;
            `AIC_OFS_IN_VAL:    rd_data[0]    = in_val;
            `AIC_OFS_LIM:       rd_data[15:0] = {q.s2[`AIC_F_REV +: 8] & AXIS_MASK,
                                                 q.s2[`AIC_F_FWD +: 8] & AXIS_MASK};
            `AIC_OFS_AXIS_SEL:  rd_data[2:0]  = q.axis_sel;
            `AIC_OFS_POS:       rd_data       = q.pos[q.axis_sel];
            `AIC_OFS_LATCH_POS: rd_data       = q.latch_pos[q.axis_sel];
            `AIC_OFS_LATCH_CFG: rd_data[11:0] = {q.lat_src, q.lat_arm};
            `AIC_OFS_IRQ_STAT:  rd_data[16:0] = q.irq_stat;
            `AIC_OFS_IRQ_MASK:  rd_data[16:0] = q.irq_mask;
            `AIC_OFS_GEN_IN:    rd_data[15:0] = q.s2[`AIC_F_GEN +: 16] & GEN_MASK;
            `AIC_OFS_LAST_ERR:  rd_data[7:0]  = q.last_err;
            default:            rd_hit        = 1'b0;
        endcase
    end

    // Next-state of the whole block
    always_comb begin
        logic [31:0] m;
        logic        blocked;
        m       = 32'h0000_0000;
        blocked = 1'b0;
        n       = q;
        n.s1    = field;
        n.s2    = q.s1;
        n.s3    = q.s2;
        n.begin_grant  = 1'b0;
        n.begin_reject = 1'b0;
        n.branch       = 1'b0;

        // Write channel
        if (aw_take) begin
            n.got_aw = 1'b1;
            n.awaddr = axi_req.awaddr;
        end
        if (w_take) begin
            n.got_w = 1'b1;
            n.wdata = axi_req.wdata;
            n.wstrb = axi_req.wstrb;
        end
        if (q.wr == aic_pkg::AIC_WR_RESP && axi_req.bready) begin
            n.wr = aic_pkg::AIC_WR_IDLE;
        end
        if (wr_fire) begin
            n.got_aw = 1'b0;
            n.got_w  = 1'b0;
            n.wr     = aic_pkg::AIC_WR_RESP;
            n.bresp  = 2'b00;
            case (wr_addr)
                `AIC_OFS_MODE: begin
                    m      = merge({24'h0, q.mode}, wr_data, wr_strb);
                    n.mode = m[7:0] & AXIS_MASK;
                end
                `AIC_OFS_STEPOUT: begin
                    m         = merge({24'h0, q.stepout}, wr_data, wr_strb);
                    n.stepout = m[7:0] & AXIS_MASK;
                end
                `AIC_OFS_OFFERR: begin
                    m        = merge({24'h0, q.offerr}, wr_data, wr_strb);
                    n.offerr = m[7:0] & AXIS_MASK;
                end
                `AIC_OFS_MOTOR: begin
                    // Writing one re-enables an axis that a limit turned off
                    if (wr_strb[0]) begin
                        n.axis_off = q.axis_off & ~wr_data[7:0];
                    end
                end
                `AIC_OFS_IN_SEL: begin
                    m        = merge({25'h0, q.in_sel}, wr_data, wr_strb);
                    n.in_sel = m[6:0];
                end
                `AIC_OFS_AXIS_SEL: begin
                    m          = merge({29'h0, q.axis_sel}, wr_data, wr_strb);
                    n.axis_sel = m[2:0];
                end
                `AIC_OFS_LATCH_CFG: begin
                    m         = merge({20'h0, q.lat_src, q.lat_arm}, wr_data, wr_strb);
                    n.lat_arm = m[7:0] & AXIS_MASK;
                    n.lat_src = m[11:8];
                end
                `AIC_OFS_IRQ_MASK: begin
                    m          = merge({15'h0, q.irq_mask}, wr_data, wr_strb);
                    n.irq_mask = m[16:0];
                end
                `AIC_OFS_IN_VAL, `AIC_OFS_LIM, `AIC_OFS_POS, `AIC_OFS_LATCH_POS,
                `AIC_OFS_IRQ_STAT, `AIC_OFS_GEN_IN, `AIC_OFS_LAST_ERR: begin
                    n.bresp = 2'b00;
                end
                default: n.bresp = 2'b10;
            endcase
        end

        // Read channel; a read of the status clears it before new events land
        if (q.rvalid && axi_req.rready) begin
            n.rvalid = 1'b0;
        end
        if (ar_take) begin
            n.rvalid = 1'b1;
            n.rdata  = rd_data;
            n.rresp  = rd_hit ? 2'b00 : 2'b10;
            if (axi_req.araddr == `AIC_OFS_IRQ_STAT) begin
                n.irq_stat = 17'h00000;
            end
        end

        // Per-axis encoder counting, limit reaction and position latch
        for (int k = 0; k < 8; k++) begin
            if (k < N_AXES) begin
                if (!q.mode[k]) begin
                    if ((a_new[k] ^ a_old[k]) ^ (b_new[k] ^ b_old[k])) begin
                        n.pos[k] = (a_new[k] ^ b_old[k]) ? q.pos[k] + 32'h1
                                                         : q.pos[k] - 32'h1;
                    end
                end else if (a_new[k] && !a_old[k]) begin
                    n.pos[k] = b_new[k] ? q.pos[k] + 32'h1 : q.pos[k] - 32'h1;
                end
                if (lim_edge[k]) begin
                    n.irq_stat[`AIC_IRQ_LIM + k] = 1'b1;
                    if (q.offerr[k]) begin
                        n.axis_off[k] = 1'b1;
                    end
                end
                if (q.lat_arm[k] && gen_chg[q.lat_src]) begin
                    n.latch_pos[k] = q.pos[k];
                    n.lat_arm[k]   = 1'b0;
                    n.irq_stat[`AIC_IRQ_LATCH + k] = 1'b1;
                end
            end
        end

        // Thread zero leaves for the handler only when one exists
        if (|lim_edge && handler_present) begin
            n.branch = 1'b1;
        end

        // Begin requests toward an active limit are refused
        if (begin_req) begin
            blocked = 32'(begin_axis) >= N_AXES
                   || (begin_fwd ? fwd_act[begin_axis] : rev_act[begin_axis]);
            if (blocked) begin
                n.begin_reject = 1'b1;
                n.last_err     = `AIC_ERR_LIMIT;
                n.irq_stat[`AIC_IRQ_BEGIN] = 1'b1;
            end else begin
                n.begin_grant = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q          <= '0;
            q.wr       <= aic_pkg::AIC_WR_IDLE;
            q.s1       <= '1; // Idle pins pull high, so no false limit edge
            q.s2       <= '1;
            q.s3       <= '1;
            q.in_sel   <= `AIC_RST_INSEL;
            q.irq_mask <= `AIC_RST_MASK;
        end else begin
            q <= n;
        end
    end

    // Outputs
    assign axi_rsp.awready = q.wr == aic_pkg::AIC_WR_IDLE && !q.got_aw;
    assign axi_rsp.wready  = q.wr == aic_pkg::AIC_WR_IDLE && !q.got_w;
    assign axi_rsp.bvalid  = q.wr == aic_pkg::AIC_WR_RESP;
    assign axi_rsp.bresp   = q.bresp;
    assign axi_rsp.arready = !q.rvalid;
    assign axi_rsp.rvalid  = q.rvalid;
    assign axi_rsp.rdata   = q.rdata;
    assign axi_rsp.rresp   = q.rresp;
    assign fwd_inhibit     = fwd_act;
    assign rev_inhibit     = rev_act;
    assign motor_enable    = ~q.axis_off & AXIS_MASK;
    assign fwd_limit_state = q.s2[`AIC_F_FWD +: 8] & AXIS_MASK;
    assign rev_limit_state = q.s2[`AIC_F_REV +: 8] & AXIS_MASK;
    assign general_input   = q.s2[`AIC_F_GEN +: 16] & GEN_MASK;
    assign enc_pos         = q.pos;
    assign begin_grant     = q.begin_grant;
    assign begin_reject    = q.begin_reject;
    assign thread0_branch  = q.branch;
    assign irq             = |(q.irq_stat & q.irq_mask);

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chk_sync_two_stage: assert property (
        ##2 fwd_limit_state[0] == $past(field.forward_travel_switch_b[0], 2))
        else $error("limit state not two cycles behind pin");

    chk_fwd_block_now: assert property (
        !field.forward_travel_switch_b[3] [*3] |-> fwd_inhibit[3])
        else $error("forward motion not blocked by active switch");

    chk_begin_refused: assert property (
        begin_req && begin_fwd && fwd_inhibit[begin_axis]
        |=> begin_reject && !begin_grant && q.last_err == 8'd22)
        else $error("begin toward active limit not refused with 22");

    chk_offerr_off: assert property (
        lim_edge[3] && q.offerr[3] |=> !motor_enable[3] [*2])
        else $error("axis not disabled on limit with off-on-error");

    chk_servo_hold: assert property (
        lim_edge[4] && !q.offerr[4] && motor_enable[4] |=> motor_enable[4])
        else $error("motor dropped on limit without off-on-error");

    chk_handler_branch: assert property (
        (|lim_edge) |=> thread0_branch == $past(handler_present))
        else $error("thread zero branch does not follow handler presence");

    chk_quad_up: assert property (
        !q.mode[0] && (a_new[0] ^ a_old[0]) && !(b_new[0] ^ b_old[0]) && (a_new[0] ^ b_old[0])
        |=> enc_pos[0] == $past(enc_pos[0]) + 32'h1)
        else $error("quadrature edge did not count up");

    chk_step_dir: assert property (
        q.mode[1] && a_new[1] && !a_old[1] && !b_new[1]
        |=> enc_pos[1] == $past(enc_pos[1]) - 32'h1)
        else $error("step with low direction did not count down");

    chk_irq_level: assert property (
        lim_edge[3] && q.irq_mask[`AIC_IRQ_LIM + 3] |=> irq)
        else $error("unmasked status did not raise interrupt");

    // Armed latch copies the count once and then disarms
    chk_latch_capture: assert property (
        q.lat_arm[0] && gen_chg[q.lat_src]
        |=> q.latch_pos[0] == $past(q.pos[0]) && !q.lat_arm[0])
        else $error("armed latch did not capture position");

    chk_aux_hidden: assert property (
        q.stepout[2] && q.in_sel == 7'd86 |-> !in_val)
        else $error("aux input visible on a stepper axis");

    chk_reject_code: assert property (
        begin_reject |-> q.last_err == `AIC_ERR_LIMIT)
        else $error("refused begin did not leave error 22");

endmodule

// ### test/aic_field_model.sv
`timescale 1ns/1ps

// Field side: encoders, travel switches and general pins, idle high like pulled-up lines
module aic_field_model (
    input  wire logic           ref_clk,
    output aic_pkg::aic_field_t f
);
    initial f = '1;

    // Edges two clocks apart, though a 25 MHz sampler also resolves edges one clock apart
    task automatic quad(input int ax, input bit up, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            if ((f.encoder_channel_one[ax] == f.encoder_channel_two[ax]) == up)
                f.encoder_channel_one[ax] <= ~f.encoder_channel_one[ax];
            else
                f.encoder_channel_two[ax] <= ~f.encoder_channel_two[ax];
            @(posedge ref_clk);
        end
    endtask

    // Direction settles well before the counted rising step edge
    task automatic pulse(input int ax, input bit up, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            f.encoder_channel_two[ax] <= up;
            f.encoder_channel_one[ax] <= 1'b0;
            repeat (2) @(posedge ref_clk);
            f.encoder_channel_one[ax] <= 1'b1;
            @(posedge ref_clk);
        end
    endtask
endmodule

// ### test/axis_input_conditioning_tb.sv
`timescale 1ns/1ps
`include "aic_regs.svh"

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module axis_input_conditioning_tb;
    logic                  ref_clk;
    logic                  rst_b;
    aic_pkg::aic_axi_req_t req;
    aic_pkg::aic_axi_rsp_t rsp;
    aic_pkg::aic_field_t   fld;
    logic                  begin_req;
    logic [2:0]            begin_axis;
    logic                  begin_fwd;
    logic                  handler_present;
    logic                  begin_grant;
    logic                  begin_reject;
    logic                  thread0_branch;
    logic [7:0]            fwd_inhibit;
    logic [7:0]            rev_inhibit;
    logic [7:0]            motor_enable;
    logic [7:0]            fwd_limit_state;
    logic [7:0]            rev_limit_state;
    logic [15:0]           general_input;
    logic [7:0][31:0]      enc_pos;
    logic                  irq;
    logic [31:0]           rd;
    logic [1:0]            rr;
    int                    seen;
    int                    err_count = 0;
    int                    n_checks = 0;
    int                    cycles = 0;

    aic_field_model u_fld (.ref_clk(ref_clk), .f(fld));

    aic_input_cond #(.N_AXES(8)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .axi_req(req), .axi_rsp(rsp), .field(fld),
        .begin_req(begin_req), .begin_axis(begin_axis), .begin_fwd(begin_fwd),
        .handler_present(handler_present), .begin_grant(begin_grant),
        .begin_reject(begin_reject), .thread0_branch(thread0_branch),
        .fwd_inhibit(fwd_inhibit), .rev_inhibit(rev_inhibit), .motor_enable(motor_enable),
        .fwd_limit_state(fwd_limit_state), .rev_limit_state(rev_limit_state),
        .general_input(general_input), .enc_pos(enc_pos), .irq(irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog: the sequence needs a few hundred cycles at most
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            stop_test();
        end
    end

    // Both write channels offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        bit aw;
        bit w;
        aw = 1'b1;
        w = 1'b1;
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        req.bready  <= 1'b1;
        while (aw || w) begin
            @(posedge ref_clk);
            aw = aw && rsp.awready !== 1'b1;
            w = w && rsp.wready !== 1'b1;
            req.awvalid <= aw;
            req.wvalid  <= w;
        end
        do @(posedge ref_clk); while (rsp.bvalid !== 1'b1);
        rr = rsp.bresp;
        req.bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic axi_rd(input logic [7:0] a);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        do @(posedge ref_clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge ref_clk); while (rsp.rvalid !== 1'b1);
        rd = rsp.rdata;
        rr = rsp.rresp;
        req.rready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        axi_rd(a);
        `CHK(rd, e)
    endtask

    task automatic in_chk(input logic [6:0] n, input logic e);
        axi_wr(`AIC_OFS_IN_SEL, {25'h0, n});
        rd_chk(`AIC_OFS_IN_VAL, {31'h0, e});
    endtask

    // Answer is due exactly one cycle after the request
    task automatic beg(input logic [2:0] ax, input logic fw, input logic [1:0] e);
        begin_req  <= 1'b1;
        begin_axis <= ax;
        begin_fwd  <= fw;
        @(posedge ref_clk);
        begin_req <= 1'b0;
        #1;
        `CHK({begin_grant, begin_reject}, e)
        @(posedge ref_clk);
    endtask

    task automatic watch();
        seen = 0;
        repeat (6) begin
            @(posedge ref_clk);
            seen += int'(thread0_branch === 1'b1);
        end
    endtask

    task automatic t_reset();
        `CHK(motor_enable, 8'hff)
        `CHK({fwd_limit_state, rev_limit_state, irq}, 17'h1fffe)
        rd_chk(`AIC_OFS_IN_SEL, 32'h1);
        rd_chk(`AIC_OFS_IRQ_MASK, 32'h0);
    endtask

    // A pin change must not show after one edge: two sync stages first
    task automatic t_gen();
        u_fld.f.general_input <= 16'h5aa5;
        @(posedge ref_clk);
        #1;
        `CHK(general_input, 16'hffff)
        repeat (3) @(posedge ref_clk);
        `CHK(general_input, 16'h5aa5)
        for (int n = 1; n <= 16; n++)
            in_chk(n[6:0], 1'(16'h5aa5 >> (n - 1)));
        in_chk(7'd17, 1'b0);
    endtask

    task automatic t_aux();
        u_fld.f.aux_channel_first[2] <= 1'b0;
        repeat (4) @(posedge ref_clk);
        in_chk(7'd85, 1'b0);
        in_chk(7'd86, 1'b1);
        in_chk(7'd96, 1'b1);
        axi_wr(`AIC_OFS_STEPOUT, 32'h4);
        in_chk(7'd86, 1'b0);
        in_chk(7'd84, 1'b1);
        axi_wr(`AIC_OFS_STEPOUT, 32'h0);
    endtask

    task automatic t_enc();
        u_fld.quad(0, 1'b1, 6);
        u_fld.quad(0, 1'b0, 2);
        repeat (4) @(posedge ref_clk);
        `CHK(enc_pos[0], 32'd4)
        axi_wr(`AIC_OFS_MODE, 32'h2);
        u_fld.pulse(1, 1'b1, 3);
        u_fld.pulse(1, 1'b0, 1);
        repeat (4) @(posedge ref_clk);
        `CHK(enc_pos[1], 32'd2)
        `CHK(enc_pos[0], 32'd4)
    endtask

    task automatic t_latch();
        axi_wr(`AIC_OFS_LATCH_CFG, 32'h1);
        axi_wr(`AIC_OFS_AXIS_SEL, 32'h0);
        u_fld.f.general_input[0] <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rd_chk(`AIC_OFS_LATCH_POS, 32'd4);
        rd_chk(`AIC_OFS_POS, 32'd4);
        rd_chk(`AIC_OFS_IRQ_STAT, 32'h100);
    endtask

    // Forward trip with off-on-error and a handler, then a reverse trip without
    task automatic t_limit();
        axi_wr(`AIC_OFS_IRQ_MASK, 32'h8);
        axi_wr(`AIC_OFS_OFFERR, 32'h8);
        handler_present <= 1'b1;
        u_fld.f.forward_travel_switch_b[3] <= 1'b0;
        watch();
        `CHK(seen, 1)
        `CHK({fwd_inhibit, rev_inhibit}, 16'h0800)
        `CHK(fwd_limit_state, 8'hf7)
        `CHK({motor_enable, irq}, {8'hf7, 1'b1})
        rd_chk(`AIC_OFS_LIM, 32'hfff7);
        rd_chk(`AIC_OFS_IRQ_STAT, 32'h8);
        `CHK(irq, 1'b0)
        beg(3'd3, 1'b1, 2'b01);
        beg(3'd3, 1'b0, 2'b10);
        rd_chk(`AIC_OFS_LAST_ERR, 32'd22);
        handler_present <= 1'b0;
        u_fld.f.reverse_travel_switch_b[4] <= 1'b0;
        watch();
        `CHK(seen, 0)
        `CHK({rev_inhibit, motor_enable, irq}, {8'h10, 8'hf7, 1'b0})
        `CHK(rev_limit_state, 8'hef)
        rd_chk(`AIC_OFS_IRQ_STAT, 32'h10010);
        u_fld.f.forward_travel_switch_b[3] <= 1'b1;
        repeat (4) @(posedge ref_clk);
        beg(3'd3, 1'b1, 2'b10);
        beg(3'd4, 1'b0, 2'b01);
        axi_wr(`AIC_OFS_MOTOR, 32'h8);
        `CHK(motor_enable, 8'hff)
    endtask

    task automatic t_bus();
        axi_wr(8'h3c, 32'h1);
        `CHK(rr, 2'b10)
        axi_rd(8'h3c);
        `CHK({rd, rr}, 34'h2)
        axi_wr(`AIC_OFS_GEN_IN, 32'h0);
        rd_chk(`AIC_OFS_GEN_IN, 32'h5aa4);
    endtask

    initial begin
        req = '0;
        begin_req = 1'b0;
        begin_axis = 3'h0;
        begin_fwd = 1'b0;
        handler_present = 1'b0;
        rst_b = 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_gen();
        t_aux();
        t_enc();
        t_latch();
        t_limit();
        t_bus();
        stop_test();
    end
endmodule
